// ### hw/radio_fifo_pkg.sv
package radio_fifo_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_THRESH = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0C;
    localparam logic [7:0] OFS_DATA = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN = 8'h18;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
    localparam logic [7:0] OFS_PRE_PAT = 8'h20;
    localparam logic [7:0] OFS_PRE_LEN = 8'h24;
    localparam logic [7:0] OFS_RX_LEN = 8'h28;
    // ----------------------------------------------------------------
    // sizes, reset values and timing
    // ----------------------------------------------------------------
    localparam int FIFO_DEPTH = 256;
    localparam logic [7:0] THRESH_RST = 8'h80;
    localparam logic [5:0] PRE_LEN_MIN = 6'd4;
    localparam logic [5:0] PRE_LEN_MAX = 6'd32;
    localparam logic [4:0] RX_LEN_RST = 5'h10;
    localparam logic [15:0] SYM_DIV = 16'h0064; // clocks per line symbol
    localparam logic [2:0] TYPE_DATA = 3'h1; // chunk type: packet data
    localparam int WHT_TAP_A = 16; // whitening x^17 + x^12 + 1
    localparam int WHT_TAP_B = 11;
    localparam logic MANCH_POL = 1'b0; // first half = coded bit ^ pol
    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic whiten;
        logic manch;
        logic diff;
        logic inv;
        logic pre_match;
        logic raw;
        logic tx_mode;
        logic enable;
    } ctrl_s; // CTRL[7:0], msb first
    typedef struct packed {
        logic free_above;
        logic fill_above;
        logic underrun;
        logic overrun;
        logic full;
        logic empty;
    } fstat_s; // STATUS[5:0] and status pins, msb first
    typedef enum logic [1:0] {
        TX_HDR = 2'b00,
        TX_PAY = 2'b01,
        TX_RAW = 2'b10
    } tx_state_e;
endpackage

// ### hw/radio_fifo.sv
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
// Operation
// (R1) single 256-byte FIFO is the data path
// (R2) FIFO holds chunks with length/type header
// (R3) FIFO direction follows transmit or receive mode
// (R4) host polls status or count without interrupts
// (R5) empty, not empty, full, not full, level interrupts
// (R6) interrupt output level, active high
// (R7) interrupt clears only when cause removed
// (R8) status bits presented on status pins always
// (R9) encoder sits between framer and modem
// (R10) inversion complements every bit
// (R11) differential: zero holds level, one toggles
// (R12) Manchester: two half symbols per bit
// (R13) self-synchronizing whitening, no added bits
// (R14) framer has packet and raw modes
// (R15) raw mode only serializes or groups bytes
// (R16) preamble match aligns bytes, 4 to 32 bits
// (R17) sticky overrun and underrun, access discarded
// (R18) polynomial, polarity, bit order fixed constants
module radio_fifo (
    input wire logic clk_in, // 100 MHz system clock
    input wire logic resetn_in, // async reset, active low
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pwrite_in, // apb direction
    input wire logic [7:0] paddr_in, // apb byte address
    input wire logic [31:0] pwdata_in, // apb write data
    output logic [31:0] prdata_out, // apb read data
    output logic pready_out, // apb ready
    output logic pslverr_out, // apb error on unmapped address
    output logic irq_out, // level interrupt, active high
    output radio_fifo_pkg::fstat_s stat_out, // status bits for serial out
    output logic tx_sym_out, // line symbol to modulator
    output logic tx_valid_out, // high while a symbol is sent
    input wire logic rx_sym_in, // line symbol from demodulator
    input wire logic rx_valid_in // one-cycle strobe per rx symbol
);
    import radio_fifo_pkg::*;

    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    // whitening feedback of a 17-bit shift register
    function automatic logic wht_fb(input logic [16:0] s);
        wht_fb = s[WHT_TAP_A] ^ s[WHT_TAP_B];
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] mem [0:FIFO_DEPTH-1]; // fifo storage
    logic [7:0] wr_ptr_r, rd_ptr_r; // fifo pointers
    logic [8:0] count_r; // fill count 0..256
    ctrl_s ctrl_r; // control register
    logic [7:0] thresh_r; // level threshold
    logic [31:0] pre_pat_r; // preamble pattern
    logic [5:0] pre_len_r; // preamble length
    logic [4:0] rx_len_r; // rx packet length
    logic ovr_r, unr_r; // sticky access errors
    logic [6:0] irq_stat_r, irq_en_r; // interrupt status, enable
    logic [15:0] div_r; // symbol divider
    logic sym_tick; // one-cycle symbol enable
    logic half_r; // manchester half phase (tx)
    logic [7:0] tx_sh_r; // tx shift register
    logic [3:0] tx_cnt_r; // tx bits left in shift register
    logic [4:0] tx_rem_r; // payload bytes left in chunk
    tx_state_e tx_st_r; // tx framer state
    logic [16:0] scr_r, dscr_r; // scrambler, descrambler
    logic lvl_r; // differential tx level
    logic line_r; // coded bit held for 2nd half
    logic rx_half_r; // manchester half phase (rx)
    logic rx_prev_r; // previous rx coded bit
    logic [31:0] hunt_r; // preamble hunt window
    logic locked_r; // preamble seen
    logic [7:0] rx_sh_r; // rx byte assembly
    logic [2:0] rx_cnt_r; // rx bits gathered
    logic [4:0] rx_rem_r; // rx bytes left in packet

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic setup, access, wr_acc, rd_acc, mapped;
    assign setup = psel_in & ~penable_in;
    assign access = psel_in & penable_in & pready_out;
    assign wr_acc = access & pwrite_in;
    assign rd_acc = access & ~pwrite_in;
    assign mapped = (paddr_in[1:0] == 2'b00) && (paddr_in <= OFS_RX_LEN);

    // ----------------------------------------------------------------
    // fifo push and pop arbitration
    // ----------------------------------------------------------------
    logic fempty, ffull, host_push, host_pop, push, pop;
    logic tx_pop, rx_push;
    logic [7:0] push_d;
    logic [7:0] rx_hdr_d, rx_byte_d;
    logic rx_hdr_go, rx_byte_go;
    assign fempty = (count_r == 9'd0);
    assign ffull = (count_r == 9'(FIFO_DEPTH));
    // host fills in tx mode and drains in rx mode [R3]
    assign host_push = wr_acc && paddr_in == OFS_DATA && ctrl_r.tx_mode;
    assign host_pop = rd_acc && paddr_in == OFS_DATA && !ctrl_r.tx_mode;
    // a full push or empty pop is dropped [R17]
    assign push = (host_push | rx_push) & ~ffull;
    assign pop = (host_pop | tx_pop) & ~fempty;
    assign rx_push = rx_hdr_go | rx_byte_go;
    assign push_d = ctrl_r.tx_mode ? pwdata_in[7:0] :
                    (rx_hdr_go ? rx_hdr_d : rx_byte_d);

    // storage: the only host/framer data path [R1]
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_r] <= push_d;
        end
    end

    // pointer and count update
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_ptr_r <= 8'h00;
            rd_ptr_r <= 8'h00;
            count_r <= 9'd0;
        end else begin
            wr_ptr_r <= wr_ptr_r + 8'(push);
            rd_ptr_r <= rd_ptr_r + 8'(pop);
            count_r <= count_r + 9'(push) - 9'(pop);
        end
    end

    // ----------------------------------------------------------------
    // status and interrupts
    // ----------------------------------------------------------------
    fstat_s fst;
    logic [6:0] irq_src;
    assign fst.empty = fempty;
    assign fst.full = ffull;
    assign fst.overrun = ovr_r;
    assign fst.underrun = unr_r;
    assign fst.fill_above = (count_r > {1'b0, thresh_r});
    assign fst.free_above = (9'(FIFO_DEPTH) - count_r > {1'b0, thresh_r});
    // source order: empty, not empty, full, not full, level, ovr, unr
    assign irq_src = {unr_r, ovr_r, fst.fill_above, ~ffull, ffull,
                      ~fempty, fempty}; // [R5]

    // sticky access errors, set wins over the clearing write
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ovr_r <= 1'b0;
            unr_r <= 1'b0;
        end else begin
            if (wr_acc && paddr_in == OFS_STATUS) begin
                ovr_r <= ovr_r & ~pwdata_in[2];
                unr_r <= unr_r & ~pwdata_in[3];
            end
            if (host_push && ffull) begin
                ovr_r <= 1'b1; // [R17]
            end
            if (host_pop && fempty) begin
                unr_r <= 1'b1; // [R17]
            end
        end
    end

    // sticky interrupt status; a live cause sets it again at once [R7]
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_stat_r <= 7'h00;
        end else if (wr_acc && paddr_in == OFS_IRQ_CLR) begin
            irq_stat_r <= (irq_stat_r & ~pwdata_in[6:0]) | irq_src;
        end else begin
            irq_stat_r <= irq_stat_r | irq_src;
        end
    end

    // level interrupt and status pins, both registered [R6] [R8]
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_out <= 1'b0;
            stat_out <= '0;
        end else begin
            irq_out <= |(irq_stat_r & irq_en_r); // [R6]
            stat_out <= fst; // bit order fixed by fstat_s [R8] [R18]
        end
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    // software writes
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_r <= '0;
            thresh_r <= THRESH_RST;
            irq_en_r <= 7'h00;
            pre_pat_r <= 32'h0000_0000;
            pre_len_r <= PRE_LEN_MAX;
            rx_len_r <= RX_LEN_RST;
        end else if (wr_acc) begin
            case (paddr_in)
                OFS_CTRL: ctrl_r <= pwdata_in[7:0];
                OFS_THRESH: thresh_r <= pwdata_in[7:0];
                OFS_IRQ_EN: irq_en_r <= pwdata_in[6:0];
                OFS_PRE_PAT: pre_pat_r <= pwdata_in;
                OFS_PRE_LEN: begin
                    // clamp to the legal 4..32 range [R16]
                    if (pwdata_in[5:0] < PRE_LEN_MIN) begin
                        pre_len_r <= PRE_LEN_MIN;
                    end else if (pwdata_in[5:0] > PRE_LEN_MAX) begin
                        pre_len_r <= PRE_LEN_MAX;
                    end else begin
                        pre_len_r <= pwdata_in[5:0];
                    end
                end
                OFS_RX_LEN: rx_len_r <= pwdata_in[4:0];
                default: ; // OFS_STATUS, OFS_DATA and OFS_IRQ_CLR writes act in other blocks; the rest read-only or unmapped
            endcase
        end
    end

    // read data and ready: no wait state, answer in the first access cycle
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else if (setup) begin
            pready_out <= 1'b1;
            pslverr_out <= ~mapped;
            case (paddr_in)
                OFS_CTRL: prdata_out <= {24'h00_0000, ctrl_r};
                OFS_THRESH: prdata_out <= {24'h00_0000, thresh_r};
                OFS_STATUS: prdata_out <= {26'h000_0000, fst}; // [R4]
                OFS_COUNT: prdata_out <= {23'h00_0000, count_r}; // [R4]
                OFS_DATA: prdata_out <= {24'h00_0000, mem[rd_ptr_r]};
                OFS_IRQ_STAT: prdata_out <= {25'h000_0000, irq_stat_r};
                OFS_IRQ_EN: prdata_out <= {25'h000_0000, irq_en_r};
                OFS_PRE_PAT: prdata_out <= pre_pat_r;
                OFS_PRE_LEN: prdata_out <= {26'h000_0000, pre_len_r};
                OFS_RX_LEN: prdata_out <= {27'h000_0000, rx_len_r};
                default: prdata_out <= 32'h0000_0000;
            endcase
        end else begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // symbol rate divider
    // ----------------------------------------------------------------
    // one tick per line symbol; each manchester half takes its own tick [R12]
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_r <= 16'h0000;
        end else if (!ctrl_r.enable || div_r == SYM_DIV - 16'h0001) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end
    assign sym_tick = ctrl_r.enable && (div_r == SYM_DIV - 16'h0001);

    // ----------------------------------------------------------------
    // tx framer: chunks to bytes to bits
    // ----------------------------------------------------------------
    logic tx_bit_go, tx_bit, s_bit, c_bit;
    assign tx_pop = ctrl_r.enable && ctrl_r.tx_mode && tx_cnt_r == 4'd0
                    && !fempty; // [R3]
    assign tx_bit_go = sym_tick && !half_r && tx_cnt_r != 4'd0;
    assign tx_bit = tx_sh_r[7]; // msb first
    // whitening then differential, then inversion [R9]
    assign s_bit = ctrl_r.whiten ? tx_bit ^ wht_fb(scr_r) : tx_bit; // [R13]
    assign c_bit = (ctrl_r.diff ? lvl_r ^ s_bit : s_bit) ^ ctrl_r.inv;

    // header is consumed, payload bytes are loaded [R14] [R2]
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_st_r <= TX_HDR;
            tx_rem_r <= 5'd0;
            tx_sh_r <= 8'h00;
            tx_cnt_r <= 4'd0;
        end else if (!ctrl_r.tx_mode) begin
            tx_st_r <= TX_HDR;
            tx_cnt_r <= 4'd0;
        end else if (tx_pop) begin
            case (ctrl_r.raw ? TX_RAW : tx_st_r)
                TX_HDR: begin
                    // header: type in [7:5], length in [4:0] [R2]
                    tx_rem_r <= mem[rd_ptr_r][4:0];
                    if (mem[rd_ptr_r][4:0] != 5'd0) begin
                        tx_st_r <= TX_PAY;
                    end
                end
                TX_PAY: begin
                    tx_sh_r <= mem[rd_ptr_r];
                    tx_cnt_r <= 4'd8;
                    tx_rem_r <= tx_rem_r - 5'd1;
                    if (tx_rem_r == 5'd1) begin
                        tx_st_r <= TX_HDR;
                    end
                end
                TX_RAW: begin
                    tx_sh_r <= mem[rd_ptr_r]; // no delimiting [R15]
                    tx_cnt_r <= 4'd8;
                end
                default: tx_st_r <= TX_HDR;
            endcase
        end else if (tx_bit_go) begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            tx_cnt_r <= tx_cnt_r - 4'd1;
        end
    end

    // tx encoder state and line output
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scr_r <= 17'h0_0000;
            lvl_r <= 1'b0;
            line_r <= 1'b0;
            half_r <= 1'b0;
            tx_sym_out <= 1'b0;
            tx_valid_out <= 1'b0;
        end else if (tx_bit_go) begin
            scr_r <= {scr_r[15:0], s_bit}; // [R13]
            lvl_r <= lvl_r ^ s_bit; // one toggles, zero holds [R11]
            line_r <= c_bit; // [R10]
            half_r <= ctrl_r.manch; // [R12]
            tx_sym_out <= ctrl_r.manch ? c_bit ^ MANCH_POL : c_bit;
            tx_valid_out <= 1'b1;
        end else if (sym_tick && half_r) begin
            half_r <= 1'b0;
            tx_sym_out <= ~(line_r ^ MANCH_POL); // mid-bit edge [R12]
        end else if (sym_tick || !ctrl_r.tx_mode) begin
            tx_valid_out <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // rx decoder: inverse transforms
    // ----------------------------------------------------------------
    logic rx_take, b_bit, d_bit, r_bit;
    // only the first half of a manchester pair carries the bit [R12]
    assign rx_take = rx_valid_in && ctrl_r.enable && !ctrl_r.tx_mode
                     && !(ctrl_r.manch && rx_half_r);
    assign b_bit = rx_sym_in ^ MANCH_POL & ctrl_r.manch ^ ctrl_r.inv;
    assign d_bit = ctrl_r.diff ? b_bit ^ rx_prev_r : b_bit; // [R11]
    assign r_bit = ctrl_r.whiten ? d_bit ^ wht_fb(dscr_r) : d_bit;

    // decoder history registers [R9]
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rx_half_r <= 1'b0;
            rx_prev_r <= 1'b0;
            dscr_r <= 17'h0_0000;
        end else begin
            if (ctrl_r.tx_mode || !ctrl_r.manch) begin
                rx_half_r <= 1'b0;
            end else if (rx_valid_in && ctrl_r.enable) begin
                rx_half_r <= ~rx_half_r;
            end
            if (rx_take) begin
                rx_prev_r <= b_bit;
                dscr_r <= {dscr_r[15:0], d_bit}; // self-sync [R13]
            end
        end
    end

    // ----------------------------------------------------------------
    // rx framer: preamble hunt, byte grouping, chunk header
    // ----------------------------------------------------------------
    logic [32:0] pre_mask;
    logic [31:0] hunt_nxt;
    logic need_lock, hit;
    assign pre_mask = (33'h1 << pre_len_r) - 33'h1;
    assign hunt_nxt = {hunt_r[30:0], r_bit};
    // packet mode always hunts; raw mode hunts if asked [R16]
    assign need_lock = !ctrl_r.raw || ctrl_r.pre_match;
    assign hit = ((hunt_nxt ^ pre_pat_r) & pre_mask[31:0]) == 32'h0;
    assign rx_hdr_d = {TYPE_DATA, rx_len_r}; // [R2]
    assign rx_byte_d = {rx_sh_r[6:0], r_bit};
    assign rx_hdr_go = rx_take && !ctrl_r.raw && !locked_r && hit; // [R14]
    assign rx_byte_go = rx_take && (locked_r || !need_lock)
                        && rx_cnt_r == 3'd7; // [R15]

    // hunt, lock and byte counters
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hunt_r <= 32'h0000_0000;
            locked_r <= 1'b0;
            rx_sh_r <= 8'h00;
            rx_cnt_r <= 3'd0;
            rx_rem_r <= 5'd0;
        end else if (ctrl_r.tx_mode || !ctrl_r.enable) begin
            locked_r <= 1'b0;
            rx_cnt_r <= 3'd0;
        end else if (rx_take) begin
            hunt_r <= hunt_nxt;
            if (need_lock && !locked_r) begin
                // discard bits until the pattern, then align [R16]
                if (hit) begin
                    locked_r <= ctrl_r.raw || rx_len_r != 5'd0;
                    rx_rem_r <= rx_len_r;
                    rx_cnt_r <= 3'd0;
                end
            end else begin
                rx_sh_r <= rx_byte_d;
                rx_cnt_r <= rx_cnt_r + 3'd1;
                if (rx_byte_go && !ctrl_r.raw) begin
                    rx_rem_r <= rx_rem_r - 5'd1;
                    if (rx_rem_r == 5'd1) begin
                        locked_r <= 1'b0; // packet done, hunt again
                    end
                end
            end
        end
    end
endmodule

// ### test/fifo_monitor.sv
`timescale 1ns/1ps
module fifo_monitor (
    input wire logic clk_in, // system clock
    input wire logic resetn_in, // async reset, active low
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pwrite_in, // apb direction
    input wire logic [7:0] paddr_in, // apb address
    input wire logic pready_out, // apb ready
    input wire logic pslverr_out, // apb error
    input wire radio_fifo_pkg::fstat_s stat_out, // buffer status
    input wire logic tx_sym_out, // line symbol
    input wire logic tx_valid_out // symbol valid
);
    import radio_fifo_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    logic st_wr; // a status write completes this edge
    assign st_wr = psel_in && penable_in && pready_out && pwrite_in
        && paddr_in == OFS_STATUS;
    // setup phase of an apb transfer
    sequence setup_s;
        psel_in && !penable_in;
    endsequence
    // first symbol of a burst
    sequence burst_start_s;
        $rose(tx_valid_out);
    endsequence
    ready_after_setup_a:
    assert property (setup_s |=> pready_out) else $error("no ready");
    ready_pulse_a:
    assert property (pready_out |=> !pready_out) else $error("long ready");
    err_with_ready_a:
    assert property (pslverr_out |-> pready_out) else $error("lone error");
    full_empty_excl_a:
    assert property (!(stat_out.full && stat_out.empty))
        else $error("full and empty together");
    overrun_sticky_a:
    assert property (stat_out.overrun && !$past(st_wr) |=> stat_out.overrun)
        else $error("overrun dropped");
    underrun_sticky_a:
    assert property (stat_out.underrun && !$past(st_wr) |=> stat_out.underrun)
        else $error("underrun dropped");
    overrun_cause_a:
    assert property ($rose(stat_out.overrun) |-> $past(stat_out.full, 2))
        else $error("overrun without full");
    symbol_hold_a:
    assert property (burst_start_s |=> $stable(tx_sym_out) [*8])
        else $error("symbol changed early");
endmodule
bind radio_fifo fifo_monitor u_mon (.clk_in(clk_in), .resetn_in(resetn_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .stat_out(stat_out), .tx_sym_out(tx_sym_out), .tx_valid_out(tx_valid_out));

// ### test/modem_model.sv
`timescale 1ns/1ps
module modem_model (
    input wire logic clk_in, // system clock
    input wire logic tx_sym_in, // line symbol from block
    input wire logic tx_valid_in, // symbol valid
    output logic rx_sym_out, // symbol to block
    output logic rx_valid_out // one-cycle symbol strobe
);
    import radio_fifo_pkg::*;
    logic [7:0] cap_r = 8'h00; // captured bits, msb first
    int nbit_r = 0; // bits captured
    int ph_r = 0; // cycles into current symbol
    initial begin
        rx_sym_out = 1'b0;
        rx_valid_out = 1'b0;
    end
    // sample each symbol mid-way
    always @(posedge clk_in) begin
        if (!tx_valid_in) begin
            ph_r <= 0;
        end else begin
            ph_r <= (ph_r == SYM_DIV - 1) ? 0 : ph_r + 1;
            if (ph_r == SYM_DIV / 2) begin
                cap_r <= {cap_r[6:0], tx_sym_in};
                nbit_r <= nbit_r + 1;
            end
        end
    end
    // send one byte msb first, a strobe every fourth clock
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_in);
            rx_sym_out <= b[i];
            rx_valid_out <= 1'b1;
            @(posedge clk_in);
            rx_valid_out <= 1'b0;
            rx_sym_out <= ~b[i]; // line no longer holds the bit
            repeat (2) @(posedge clk_in);
        end
    endtask
endmodule

// ### test/radio_bitstream_encoder_fifo_test.sv
`timescale 1ns/1ps
module radio_bitstream_encoder_fifo_test;
    import radio_fifo_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, irq, tx_sym, tx_valid, rx_sym, rx_valid, er;
    fstat_s stat;
    int err_count = 0, n_compared = 0, cyc = 0;
    radio_fifo u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .irq_out(irq), .stat_out(stat),
        .tx_sym_out(tx_sym), .tx_valid_out(tx_valid), .rx_sym_in(rx_sym),
        .rx_valid_in(rx_valid));
    modem_model u_mdm (.clk_in(clk_in), .tx_sym_in(tx_sym),
        .tx_valid_in(tx_valid), .rx_sym_out(rx_sym), .rx_valid_out(rx_valid));
    initial forever #5 clk_in = ~clk_in;
    // cut a hung run short
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            close_out;
        end
    end
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_in);
    endtask
    task automatic t_reset;
        rdchk("thresh", OFS_THRESH, 32'h0000_0080);
        rdchk("count", OFS_COUNT, 32'h0000_0000);
        chk("stat", 32'h0000_0021, stat);
        apb(1'b0, 8'h2C, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, er);
    endtask
    // fill in transmit direction with the framer held off
    task automatic t_fill;
        apb(1'b1, OFS_CTRL, 32'h0000_0002);
        for (int i = 0; i < FIFO_DEPTH; i++) apb(1'b1, OFS_DATA, i);
        rdchk("count full", OFS_COUNT, 32'h0000_0100);
        chk("full", 32'h0000_0001, stat.full);
        chk("irq masked", 32'h0000_0000, irq);
        apb(1'b1, OFS_IRQ_EN, 32'h0000_0004);
        apb(1'b1, OFS_DATA, 32'h0000_00EE);
        settle;
        chk("irq full", 32'h0000_0001, irq);
        chk("overrun", 32'h0000_0001, stat.overrun);
        apb(1'b1, OFS_IRQ_CLR, 32'h0000_0004);
        settle;
        chk("irq held", 32'h0000_0001, irq);
        apb(1'b1, OFS_STATUS, 32'h0000_0004);
        settle;
        chk("overrun clr", 32'h0000_0000, stat.overrun);
    endtask
    // drain in receive direction, oldest byte first
    task automatic t_drain;
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            apb(1'b0, OFS_DATA, 32'h0000_0000);
            chk("data", i[7:0], rd[7:0]);
        end
        apb(1'b0, OFS_DATA, 32'h0000_0000);
        settle;
        chk("empty", 32'h0000_0001, stat.empty);
        chk("underrun", 32'h0000_0001, stat.underrun);
        apb(1'b1, OFS_IRQ_CLR, 32'h0000_007F);
        apb(1'b1, OFS_STATUS, 32'h0000_0008);
        settle;
        chk("irq cleared", 32'h0000_0000, irq);
    endtask
    // raw differential inverted transmit of one byte
    task automatic t_tx;
        apb(1'b1, OFS_CTRL, 32'h0000_0037);
        apb(1'b1, OFS_DATA, 32'h0000_00A5);
        while (u_mdm.nbit_r < 8) @(posedge clk_in);
        chk("tx bits", 32'h0000_0039, u_mdm.cap_r);
    endtask
    // raw receive of one byte raises the not-empty interrupt
    task automatic t_rx;
        apb(1'b1, OFS_IRQ_EN, 32'h0000_0002);
        apb(1'b1, OFS_CTRL, 32'h0000_0005);
        apb(1'b1, OFS_IRQ_CLR, 32'h0000_007F);
        u_mdm.send_byte(8'h3C);
        settle;
        chk("irq rx", 32'h0000_0001, irq);
        rdchk("count rx", OFS_COUNT, 32'h0000_0001);
        rdchk("rx byte", OFS_DATA, 32'h0000_003C);
        apb(1'b1, OFS_IRQ_CLR, 32'h0000_007F);
        settle;
        chk("irq gone", 32'h0000_0000, irq);
    endtask
    initial begin
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
        t_reset;
        t_fill;
        t_drain;
        t_tx;
        t_rx;
        close_out;
    end
endmodule
